// >>> dma_direct_completion_program.sv
// direct programming of one transfer controller and completion bookkeeping
// assumes a single-cycle register port and one software master at a time
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dma_direct_completion_program
#(
	parameter logic [31:0] TC_PID_ADDR = 32'h00000000, // controller identification location
	parameter logic [31:0] CC_PID_ADDR = 32'h00004000 // channel controller identification location
)
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// register port
	input wire logic [11:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// channel controller side
	input wire logic tr_submit_i,
	output logic cc_stall_o,
	output logic cc_err_irq_o,
	// transfer controller side
	output logic tc_err_irq_o,
	output logic xfer_busy_o
);
	localparam int SHORT_WAIT = dma_direct_pkg::SHORT_LAT_CYC + 1; // launch to done
	localparam int PID_WAIT = dma_direct_pkg::PID_LAT_CYC + 1; // launch to done

	logic [31:0] opt_r; // options
	logic [31:0] src_r; // source address
	logic [31:0] cnt_cfg_r; // frame and byte count
	logic [31:0] dst_r; // destination address
	logic [31:0] fidx_r; // frame index
	logic bus_error_flag_r; // error status bit
	logic [1:0] err_det_r; // which side hit the reserved location
	logic [5:0] err_det_code_r; // code of the failing transfer
	logic err_en_r; // error enable
	logic [63:0] pend_r; // pending bits, low then high word
	logic [5:0] outstanding_completion_count; // outstanding completions
	logic completion_code_error; // saturation flag
	logic cc_err_en_r; // channel error enable
	logic xf_rsv_r; // running transfer hit the reserved location
	logic [1:0] xf_side_r; // which side hit it
	logic xf_report_r; // running transfer reports completion
	logic [5:0] xf_code_r; // running transfer's code
	logic [31:0] rdata_nxt; // read mux
	logic launch; // frame index write
	logic done; // transfer finished
	logic dec; // completion returns a code
	logic inc; // channel controller submits a reporting request
	logic [5:0] count_nxt; // next outstanding count
	logic src_rsv, dst_rsv, any_pid; // address classes
	logic [7:0] lat_sel; // latency of the launch

	// write decode helpers
	function automatic logic wr_at(input logic [11:0] ofs);
		wr_at = reg_wr_i && (reg_addr_i == ofs);
	endfunction

	// written out, since a function reading port signals hides them from a continuous assignment
	assign launch = reg_wr_i && (reg_addr_i == dma_direct_pkg::OFS_FIDX);
	assign src_rsv = (src_r == dma_direct_pkg::RSV_ADDR);
	assign dst_rsv = (dst_r == dma_direct_pkg::RSV_ADDR);
	assign any_pid = (src_r == TC_PID_ADDR) || (src_r == CC_PID_ADDR)
		|| (dst_r == TC_PID_ADDR) || (dst_r == CC_PID_ADDR);

	// reserved location is the quick path, identification the slow one
	always_comb
	begin
		if (src_rsv || dst_rsv)
			lat_sel = 8'(dma_direct_pkg::SHORT_LAT_CYC);
		else if (any_pid)
			lat_sel = 8'(dma_direct_pkg::PID_LAT_CYC);
		else
			lat_sel = 8'(dma_direct_pkg::NORMAL_LAT_CYC);
	end

	// engine instance; a launch while busy is ignored
	dma_direct_xfer_timer u_timer
	(
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.start_i(launch),
		.lat_i(lat_sel),
		.busy_o(xfer_busy_o),
		.done_o(done)
	);

	// programming set; reserved option bits never store
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			opt_r <= dma_direct_pkg::OPT_RST;
			src_r <= dma_direct_pkg::ADDR_RST;
			cnt_cfg_r <= dma_direct_pkg::ADDR_RST;
			dst_r <= dma_direct_pkg::ADDR_RST;
			fidx_r <= dma_direct_pkg::ADDR_RST;
		end
		else
		begin
			if (wr_at(dma_direct_pkg::OFS_OPTIONS))
				opt_r <= reg_wdata_i & dma_direct_pkg::OPT_MASK;
			if (wr_at(dma_direct_pkg::OFS_SRC))
				src_r <= reg_wdata_i;
			if (wr_at(dma_direct_pkg::OFS_COUNT))
				cnt_cfg_r <= reg_wdata_i;
			if (wr_at(dma_direct_pkg::OFS_DST))
				dst_r <= reg_wdata_i;
			if (launch)
				fidx_r <= reg_wdata_i;
		end
	end

	// snapshot at launch, so later writes cannot corrupt a running transfer
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			xf_rsv_r <= 1'b0;
			xf_side_r <= 2'b00;
			xf_report_r <= 1'b0;
			xf_code_r <= 6'h00;
		end
		else if (launch && !xfer_busy_o)
		begin
			xf_rsv_r <= src_rsv || dst_rsv;
			xf_side_r <= {dst_rsv, src_rsv};
			xf_report_r <= opt_r[dma_direct_pkg::OPT_IRQ_BIT] || opt_r[dma_direct_pkg::OPT_CHAIN_BIT];
			xf_code_r <= opt_r[dma_direct_pkg::OPT_CODE_MSB:dma_direct_pkg::OPT_CODE_LSB];
		end
	end

	// bus error status and details; set beats a write-one clear
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			bus_error_flag_r <= 1'b0;
			err_det_r <= 2'b00;
			err_det_code_r <= 6'h00;
			err_en_r <= 1'b0;
		end
		else
		begin
			if (done && xf_rsv_r)
			begin
				bus_error_flag_r <= 1'b1;
				err_det_r <= xf_side_r;
				err_det_code_r <= xf_code_r;
			end
			else if (wr_at(dma_direct_pkg::OFS_ERR_STAT) && reg_wdata_i[0])
				bus_error_flag_r <= 1'b0;
			if (wr_at(dma_direct_pkg::OFS_ERR_EN))
				err_en_r <= reg_wdata_i[0];
		end
	end

	assign dec = done && xf_report_r;

	// one pending flop per code; completion beats a same-cycle clear
	genvar gi;
	generate
		for (gi = 0; gi < 64; gi++)
		begin : g_pend
			always_ff @(posedge mclk_i)
			begin
				if (!nrst_i)
					pend_r[gi] <= 1'b0;
				else if (dec && (xf_code_r == 6'(gi)))
					pend_r[gi] <= 1'b1;
				else if (wr_at((gi < 32) ? dma_direct_pkg::OFS_CLR_LO : dma_direct_pkg::OFS_CLR_HI)
					&& reg_wdata_i[gi % 32])
					pend_r[gi] <= 1'b0;
			end
		end
	endgenerate

	// counter moves only by channel submissions and returned codes
	assign inc = tr_submit_i && !cc_stall_o;
	assign count_nxt = outstanding_completion_count + {5'b0, inc} - {5'b0, dec};

	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			outstanding_completion_count <= dma_direct_pkg::CNT_RST;
		else
			outstanding_completion_count <= count_nxt;
	end

	// stall mirrors saturation; no underflow guard, so roll-under saturates too
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			cc_stall_o <= 1'b0;
		else
			cc_stall_o <= (count_nxt == dma_direct_pkg::CNT_MAX);
	end

	// channel error flag and its enable; saturation beats a clear
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			completion_code_error <= 1'b0;
			cc_err_en_r <= 1'b0;
		end
		else
		begin
			if (count_nxt == dma_direct_pkg::CNT_MAX)
				completion_code_error <= 1'b1;
			else if (wr_at(dma_direct_pkg::OFS_CC_ERR) && reg_wdata_i[0])
				completion_code_error <= 1'b0;
			if (wr_at(dma_direct_pkg::OFS_CC_ERR_EN))
				cc_err_en_r <= reg_wdata_i[0];
		end
	end

	// error interrupts, each gated by its enable
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			tc_err_irq_o <= 1'b0;
			cc_err_irq_o <= 1'b0;
		end
		else
		begin
			tc_err_irq_o <= bus_error_flag_r && err_en_r;
			cc_err_irq_o <= completion_code_error && cc_err_en_r;
		end
	end

	// read mux; unmapped offsets and clear registers read zero
	always_comb
	begin
		unique case (reg_addr_i)
			dma_direct_pkg::OFS_OPTIONS: rdata_nxt = opt_r;
			dma_direct_pkg::OFS_SRC: rdata_nxt = src_r;
			dma_direct_pkg::OFS_COUNT: rdata_nxt = cnt_cfg_r;
			dma_direct_pkg::OFS_DST: rdata_nxt = dst_r;
			dma_direct_pkg::OFS_FIDX: rdata_nxt = fidx_r;
			dma_direct_pkg::OFS_ERR_STAT: rdata_nxt = {31'b0, bus_error_flag_r};
			dma_direct_pkg::OFS_ERR_DET: rdata_nxt = {14'b0, err_det_code_r, 10'b0, err_det_r};
			dma_direct_pkg::OFS_ERR_EN: rdata_nxt = {31'b0, err_en_r};
			dma_direct_pkg::OFS_PEND_LO: rdata_nxt = pend_r[31:0];
			dma_direct_pkg::OFS_PEND_HI: rdata_nxt = pend_r[63:32];
			dma_direct_pkg::OFS_CNT_STAT: rdata_nxt = {26'b0, outstanding_completion_count};
			dma_direct_pkg::OFS_CC_ERR: rdata_nxt = {31'b0, completion_code_error};
			dma_direct_pkg::OFS_CC_ERR_EN: rdata_nxt = {31'b0, cc_err_en_r};
			default: rdata_nxt = 32'h00000000;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			reg_rdata_o <= 32'h00000000;
		else
			reg_rdata_o <= reg_rd_i ? rdata_nxt : 32'h00000000;
	end

	a_count_wrap: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(dec && !inc && outstanding_completion_count == 6'h00) |=> outstanding_completion_count == 6'h3F)
		else $error("counter did not wrap to max");
	a_launch_source: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$rose(xfer_busy_o) |-> $past(reg_wr_i) && $past(reg_addr_i) == 12'h210)
		else $error("transfer started without index write");
	a_pend_set: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		dec |=> pend_r[$past(xf_code_r)])
		else $error("pending bit not set on completion");
	a_opt_reserved: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(opt_r & 32'hFFAC088C) == 32'h00000000)
		else $error("reserved option bit stored");
	a_rsv_fast: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(launch && !xfer_busy_o && (src_rsv || dst_rsv)) |-> ##SHORT_WAIT done ##1 bus_error_flag_r)
		else $error("reserved transfer timing or error wrong");
	a_irq_gated: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!err_en_r |=> !tc_err_irq_o)
		else $error("bus error interrupt while disabled");
	a_pid_slow: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(launch && !xfer_busy_o && !src_rsv && !dst_rsv && any_pid && !bus_error_flag_r)
		|-> ##PID_WAIT (done && !xf_rsv_r) ##1 !bus_error_flag_r)
		else $error("identification transfer timing wrong");
	a_no_direct_inc: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(launch && !tr_submit_i && !dec) |=> $stable(outstanding_completion_count))
		else $error("direct launch moved the counter");
	a_stall_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(cc_stall_o && !dec) |=> outstanding_completion_count == 6'h3F && cc_stall_o)
		else $error("saturated counter moved without completion");
	a_sat_flag: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(outstanding_completion_count == 6'h3F && !dec) |=> completion_code_error)
		else $error("saturation did not set error flag");
endmodule
`default_nettype wire

// >>> dma_direct_pkg.sv
// shared constants for the direct-programming completion block
// assumes a 12-bit byte offset from the transfer controller base
package dma_direct_pkg;
	// direct programming set, written in this order
	localparam logic [11:0] OFS_OPTIONS = 12'h200;
	localparam logic [11:0] OFS_SRC = 12'h204;
	localparam logic [11:0] OFS_COUNT = 12'h208;
	localparam logic [11:0] OFS_DST = 12'h20C;
	localparam logic [11:0] OFS_FIDX = 12'h210;
	// transfer controller error registers
	localparam logic [11:0] OFS_ERR_STAT = 12'h300;
	localparam logic [11:0] OFS_ERR_DET = 12'h304;
	localparam logic [11:0] OFS_ERR_EN = 12'h308;
	// completion pending and clear registers
	localparam logic [11:0] OFS_PEND_LO = 12'h400;
	localparam logic [11:0] OFS_PEND_HI = 12'h404;
	localparam logic [11:0] OFS_CLR_LO = 12'h408;
	localparam logic [11:0] OFS_CLR_HI = 12'h40C;
	// channel controller status and error
	localparam logic [11:0] OFS_CNT_STAT = 12'h410;
	localparam logic [11:0] OFS_CC_ERR = 12'h414;
	localparam logic [11:0] OFS_CC_ERR_EN = 12'h418;
	// options field layout
	localparam int OPT_CHAIN_BIT = 22;
	localparam int OPT_IRQ_BIT = 20;
	localparam int OPT_CODE_LSB = 12;
	localparam int OPT_CODE_MSB = 17;
	localparam logic [31:0] OPT_MASK = 32'h0053F773;
	localparam logic [31:0] OPT_RST = 32'h00000000;
	localparam logic [31:0] ADDR_RST = 32'h00000000;
	// error details layout
	localparam int DET_SRC_BIT = 0;
	localparam int DET_DST_BIT = 1;
	// reserved fast-completion location
	localparam logic [31:0] RSV_ADDR = 32'h31000000;
	// outstanding counter
	localparam logic [5:0] CNT_RST = 6'h00;
	localparam logic [5:0] CNT_MAX = 6'h3F;
	// latencies of a direct transfer
	localparam int CLK_PERIOD_NS = 50;
	localparam int SHORT_LAT_NS = 200;
	localparam int NORMAL_LAT_NS = 500;
	localparam int PID_LAT_NS = 1000;
	localparam int SHORT_LAT_CYC = (SHORT_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NORMAL_LAT_CYC = (NORMAL_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PID_LAT_CYC = (PID_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// transfer engine states
	typedef enum logic {XF_IDLE, XF_RUN} xfer_state_type;
endpackage

// >>> dma_direct_xfer_timer.sv
// latency timer standing in for the data movement of one direct transfer
// assumes start_i is a one-cycle pulse and lat_i is at least one
`timescale 1ns/100ps
`default_nettype none
module dma_direct_xfer_timer
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// launch
	input wire logic start_i,
	input wire logic [7:0] lat_i,
	// progress
	output logic busy_o,
	output logic done_o
);
	dma_direct_pkg::xfer_state_type state_r; // engine state
	logic [7:0] cnt_r; // cycles left

	// state and countdown; a start while running is dropped
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			state_r <= dma_direct_pkg::XF_IDLE;
			cnt_r <= 8'h00;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			unique case (state_r)
				dma_direct_pkg::XF_IDLE:
				begin
					if (start_i)
					begin
						state_r <= dma_direct_pkg::XF_RUN;
						cnt_r <= lat_i - 8'h01;
					end
				end
				dma_direct_pkg::XF_RUN:
				begin
					if (cnt_r == 8'h00)
					begin
						state_r <= dma_direct_pkg::XF_IDLE;
						done_o <= 1'b1;
					end
					else
						cnt_r <= cnt_r - 8'h01;
				end
			endcase
		end
	end

	// busy follows the state so it is a flop of its own
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			busy_o <= 1'b0;
		else
			busy_o <= (state_r == dma_direct_pkg::XF_RUN) ? !(cnt_r == 8'h00) : start_i;
	end
endmodule
`default_nettype wire

// >>> cc_request_source.sv
// channel controller model that submits completion-reporting requests
// assumes load_i is a one-cycle pulse driven just after a clock edge
`timescale 1ns/100ps
`default_nettype none
module cc_request_source
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// command from the bench
	input wire logic [3:0] burst_i,
	input wire logic load_i,
	// request towards the block
	output logic tr_submit_o
);
	logic [3:0] left_r; // requests still to issue

	// one request per cycle, back to back, so a stall is hit mid-burst
	// the model only submits requests and never touches the direct registers
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			left_r <= 4'h0;
		else if (load_i)
			left_r <= burst_i;
		else if (left_r != 4'h0)
			left_r <= left_r - 4'h1;
	end

	// level straight from the register, changes just after the edge
	assign tr_submit_o = (left_r != 4'h0);
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the direct-programming completion block
// assumes a 20 MHz clock and the single-cycle register port of the design
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic mclk_i = 1'b0; // system clock
	logic nrst_i = 1'b0; // synchronous reset, active low
	logic [11:0] reg_addr_i = 12'h000;
	logic [31:0] reg_wdata_i = 32'h00000000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic tr_submit_i; // driven by the partner
	logic cc_stall_o, cc_err_irq_o, tc_err_irq_o, xfer_busy_o;
	logic [3:0] burst = 4'h0; // partner burst length
	logic load = 1'b0; // partner start pulse
	logic [31:0] cnt; // last counter reading
	logic [11:0] opt_hi = 12'h001; // options bits 31:20 of a decrement transfer
	int n_mismatch = 0;
	int samples_checked = 0;
	int k;

	// half period of 25 ns
	always #25 mclk_i = ~mclk_i;

	dma_direct_completion_program DUT
	(
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.tr_submit_i(tr_submit_i),
		.cc_stall_o(cc_stall_o),
		.cc_err_irq_o(cc_err_irq_o),
		.tc_err_irq_o(tc_err_irq_o),
		.xfer_busy_o(xfer_busy_o)
	);

	cc_request_source partner
	(
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.burst_i(burst),
		.load_i(load),
		.tr_submit_o(tr_submit_i)
	);

	// verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// word compare
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	// flag compare, value taken when called, compared after a 1 ns delay
	task automatic chk_bit(input logic got, input logic exp);
		#1;
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
		end
	endtask

	// one write cycle, then a gap so strobes never double-assign
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask

	// one read cycle, data taken in the cycle after the strobe only
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
		@(posedge mclk_i);
	endtask

	// read and compare
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk_reg(d, exp);
	endtask

	// partner burst of completion-reporting requests
	task automatic submit(input logic [3:0] b);
		burst <= b;
		load <= 1'b1;
		@(posedge mclk_i);
		load <= 1'b0;
		repeat (8) @(posedge mclk_i);
	endtask

	// decrement transfer in software order; dup relaunches while busy
	task automatic xfer(input logic [31:0] adr, input logic [5:0] code, input logic dup, input int lat);
		int n;
		logic ended;
		n = 0;
		ended = 1'b0;
		wr(dma_direct_pkg::OFS_OPTIONS, {opt_hi, 2'h0, code, 12'h000});
		wr(dma_direct_pkg::OFS_SRC, adr);
		wr(dma_direct_pkg::OFS_COUNT, 32'h00010004);
		wr(dma_direct_pkg::OFS_DST, adr);
		chk_bit(xfer_busy_o, 1'b0);
		reg_addr_i <= dma_direct_pkg::OFS_FIDX;
		reg_wdata_i <= 32'h00000000;
		reg_wr_i <= 1'b1;
		// count busy cycles; a second launch must be dropped
		while (!ended && n < 100)
		begin
			@(posedge mclk_i);
			reg_wr_i <= (dup && n == 1);
			#1;
			if (xfer_busy_o === 1'b1)
				n++;
			else
				ended = 1'b1;
		end
		if (!ended)
		begin
			n_mismatch++;
			$display("MISMATCH %0t transfer never ended", $time);
			close_out;
		end
		chk_reg(n, lat);
		// completion lands at the next edge
		@(posedge mclk_i);
	endtask

	// main sequence
	initial
	begin
		repeat (10) @(posedge mclk_i);
		nrst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		// reset values, masking, unmapped place
		rdc(dma_direct_pkg::OFS_OPTIONS, 32'h00000000);
		rdc(dma_direct_pkg::OFS_CNT_STAT, 32'h00000000);
		rdc(12'h7FC, 32'h00000000);
		wr(dma_direct_pkg::OFS_OPTIONS, 32'hFFFFFFFF);
		rdc(dma_direct_pkg::OFS_OPTIONS, 32'h0053F773);
		wr(dma_direct_pkg::OFS_SRC, 32'hA5A5A5A5);
		rdc(dma_direct_pkg::OFS_SRC, 32'hA5A5A5A5);
		// reserved address from an empty counter: fast, error, roll under
		xfer(32'h31000000, 6'h3F, 1'b0, 4);
		rdc(dma_direct_pkg::OFS_PEND_HI, 32'h80000000);
		rdc(dma_direct_pkg::OFS_PEND_LO, 32'h00000000);
		rdc(dma_direct_pkg::OFS_CNT_STAT, 32'h0000003F);
		chk_bit(cc_stall_o, 1'b1);
		rdc(dma_direct_pkg::OFS_CC_ERR, 32'h00000001);
		rdc(dma_direct_pkg::OFS_ERR_STAT, 32'h00000001);
		rdc(dma_direct_pkg::OFS_ERR_DET, 32'h0003F003);
		chk_bit(tc_err_irq_o, 1'b0);
		chk_bit(cc_err_irq_o, 1'b0);
		submit(4'h1);
		rdc(dma_direct_pkg::OFS_CNT_STAT, 32'h0000003F);
		wr(dma_direct_pkg::OFS_ERR_EN, 32'h00000001);
		wr(dma_direct_pkg::OFS_CC_ERR_EN, 32'h00000001);
		chk_bit(tc_err_irq_o, 1'b1);
		chk_bit(cc_err_irq_o, 1'b1);
		wr(dma_direct_pkg::OFS_ERR_STAT, 32'h00000001);
		wr(dma_direct_pkg::OFS_ERR_EN, 32'h00000000);
		wr(dma_direct_pkg::OFS_CLR_HI, 32'h80000000);
		rdc(dma_direct_pkg::OFS_ERR_STAT, 32'h00000000);
		chk_bit(tc_err_irq_o, 1'b0);
		rdc(dma_direct_pkg::OFS_PEND_HI, 32'h00000000);
		rdc(dma_direct_pkg::OFS_CLR_HI, 32'h00000000);
		// identification location: slower, no error
		xfer(32'h00000000, 6'h05, 1'b0, 20);
		rdc(dma_direct_pkg::OFS_ERR_STAT, 32'h00000000);
		rdc(dma_direct_pkg::OFS_PEND_LO, 32'h00000020);
		rdc(dma_direct_pkg::OFS_CNT_STAT, 32'h0000003E);
		chk_bit(cc_stall_o, 1'b0);
		wr(dma_direct_pkg::OFS_CLR_LO, 32'h00000020);
		// plain address, relaunch while busy is dropped
		xfer(32'h00001000, 6'h20, 1'b1, 10);
		rdc(dma_direct_pkg::OFS_PEND_HI, 32'h00000001);
		rdc(dma_direct_pkg::OFS_CNT_STAT, 32'h0000003D);
		wr(dma_direct_pkg::OFS_CLR_HI, 32'h00000001);
		// requests saturate the counter, extra ones ignored
		submit(4'h4);
		rdc(dma_direct_pkg::OFS_CNT_STAT, 32'h0000003F);
		chk_bit(cc_stall_o, 1'b1);
		// decrement until below the threshold
		rd(dma_direct_pkg::OFS_CNT_STAT, cnt);
		k = 0;
		while (cnt >= 32'h00000020 && k < 40)
		begin
			xfer(32'h31000000, 6'h3F, 1'b0, 4);
			rdc(dma_direct_pkg::OFS_PEND_HI, 32'h80000000);
			wr(dma_direct_pkg::OFS_CLR_HI, 32'h80000000);
			rd(dma_direct_pkg::OFS_CNT_STAT, cnt);
			chk_reg(cnt, 32'h0000003E - k);
			k++;
		end
		chk_reg(cnt, 32'h0000001F);
		chk_bit(cc_stall_o, 1'b0);
		// chain enable alone still reports; no enable reports nothing
		opt_hi = 12'h004;
		xfer(32'h00001000, 6'h01, 1'b0, 10);
		rdc(dma_direct_pkg::OFS_PEND_LO, 32'h00000002);
		rdc(dma_direct_pkg::OFS_CNT_STAT, 32'h0000001E);
		wr(dma_direct_pkg::OFS_CLR_LO, 32'h00000002);
		opt_hi = 12'h000;
		xfer(32'h00001000, 6'h02, 1'b0, 10);
		rdc(dma_direct_pkg::OFS_PEND_LO, 32'h00000000);
		rdc(dma_direct_pkg::OFS_CNT_STAT, 32'h0000001E);
		close_out;
	end
endmodule
`default_nettype wire
